/* rtl/dns_ddc.sv */
// DDC NCO phase alignment, accumulators and decimation filter chain.
// Assumes mixer samples and flags arrive on the device clock; SYNC and
// SYSREF arrive from pins and are resynchronised here.

// =========================================================================
// Folded half-band decimate-by-two stage
module dns_halfband_stage
#(
   parameter int IDX = 0
)
(
   // Clock and reset.
   input  wire logic               clock,
   input  wire logic               arst_n,
   // Complex samples in.
   input  wire logic               inValid,
   input  wire logic signed [14:0] inI,
   input  wire logic signed [14:0] inQ,
   // Complex samples out, every second input.
   output logic                    outValid,
   output logic signed [14:0]      outI,
   output logic signed [14:0]      outQ
);
   localparam int NH = dns_pkg::STG_NH[IDX];
   localparam int L  = 4 * NH - 1;

   logic signed [14:0] tap      [2][L];
   logic signed [14:0] next_tap [2][L];
   logic               phase;
   logic               next_phase;
   logic               next_outValid;
   logic signed [14:0] next_outI;
   logic signed [14:0] next_outQ;

   // Shift both rails and fold mirrored taps onto one multiplier each.
   always_comb
   begin : stage_next
      logic signed [47:0] acc;
      logic signed [15:0] pair;
      logic signed [14:0] res [2];
      acc = '0;
      pair = '0;
      res = '{default: '0};
      next_tap = tap;
      next_phase = phase;
      next_outValid = 1'b0;
      if (inValid)
      begin
         next_tap[0][0] = inI;
         next_tap[1][0] = inQ;
         for (int t = 1; t < L; t++)
         begin
            next_tap[0][t] = tap[0][t-1];
            next_tap[1][t] = tap[1][t-1];
         end
         next_phase = !phase;
         next_outValid = phase;
      end
      for (int c = 0; c < 2; c++)
      begin
         acc = 48'(dns_pkg::STG_CTR[IDX]) * 48'(next_tap[c][2*NH-1]);
         for (int k = 0; k < NH; k++)
         begin
            pair = 16'(next_tap[c][2*k]) + 16'(next_tap[c][L-1-2*k]);
            acc = acc + 48'(dns_pkg::STG_COEF[IDX][k]) * 48'(pair);
         end
         res[c] = 15'(acc >>> dns_pkg::STG_SHIFT[IDX]);
      end
      next_outI = next_outValid ? res[0] : outI;
      next_outQ = next_outValid ? res[1] : outQ;
   end

   // Stage registers.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tap      <= '{default: '{default: '0}};
         phase    <= 1'b0;
         outValid <= 1'b0;
         outI     <= '0;
         outQ     <= '0;
      end
      else
      begin
         tap      <= next_tap;
         phase    <= next_phase;
         outValid <= next_outValid;
         outI     <= next_outI;
         outQ     <= next_outQ;
      end
   end
endmodule : dns_halfband_stage

// =========================================================================
// Top level
// Functional notes
// - SYNC low with link and SYNC enabled arms; 8b/10b also starts code group alignment.
// - NCOs align on SYNC rising; receiver releases all devices together.
// - Writing one to the arm bit arms alignment on a later SYSREF.
// - DC case: one SYSREF pulse aligns NCOs in every armed device.
// - Armed device aligns on first SYSREF rising edge after arming.
// - Stages filter complex samples, 15-bit outputs, linear-phase FIR.
// - Factors 4 to 32 divide output rate; bypass gives real 12-bit.
// - Decimating modes keep 0.8 of output rate, 90 dB, 0.001 dB.
// - Stage order: 4 d,e; 8 c-e; 16 b-e; 32 a-e.
// - Symmetric coefficients around one centre tap, folded multipliers.
// - Decimated output I word carries low flag, Q word carries high flag.
module dns_ddc_nco_sync
(
   // Clock and reset.
   input  wire logic               clock,
   input  wire logic               arst_n,
   // AXI4-Lite write channels.
   input  wire logic [7:0]         awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // AXI4-Lite read channels.
   input  wire logic [7:0]         araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Alignment pins, asynchronous.
   input  wire logic               syncReqN,
   input  wire logic               sysref,
   // Mixer and threshold inputs.
   input  wire logic               mixValid,
   input  wire logic signed [14:0] mixI,
   input  wire logic signed [14:0] mixQ,
   input  wire logic               realValid,
   input  wire logic [11:0]        realIn,
   input  wire logic               overrangeFlagLow,
   input  wire logic               overrangeFlagHigh,
   // NCO phase to the mixer and link status.
   output logic [15:0]             ncoPhaseA,
   output logic [15:0]             ncoPhaseB,
   output logic                    ncoAlignPulse,
   output logic                    codeGroupAlignment,
   // Output samples toward the link.
   output logic                    ddcValid,
   output logic [15:0]             ddcI,
   output logic [15:0]             ddcQ
);
   import dns_pkg::*;
   logic [31:0] ctrl, next_ctrl;
   logic [31:0] chanANcoFreqWord [4], next_fa [4];
   logic [31:0] chanBNcoFreqWord [4], next_fb [4];
   logic [15:0] chanANcoPhaseWord [4], next_pa [4];
   logic [15:0] chanBNcoPhaseWord [4], next_pb [4];
   logic [7:0]  awAddr, next_awAddr;
   logic [31:0] wData, next_wData;
   logic [3:0]  wStrb, next_wStrb;
   logic        awHave, next_awHave, wHave, next_wHave;
   logic        next_awready, next_wready, next_bvalid, next_arready;
   logic        next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic        armSet;
   logic [2:0]  syncPipe, srefPipe;
   logic        syncLvl, srefLvl, next_syncLvl, next_srefLvl;
   logic        nextSysrefNcoAlignArm, next_arm;
   logic        syncArmed, next_syncArmed, next_cga;
   logic        alignNow;
   logic [7:0]  alignCount, next_alignCount;
   logic [31:0] accA [4], accB [4], next_accA [4], next_accB [4];
   logic [15:0] next_phA, next_phB;

   // Byte-lane merge for register writes.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // =====================================================================
   // Register file and AXI4-Lite slave
   always_comb
   begin : bus_next
      logic [2:0] ix;
      ix = 3'h0;
      next_ctrl = ctrl;
      next_fa = chanANcoFreqWord;
      next_fb = chanBNcoFreqWord;
      next_pa = chanANcoPhaseWord;
      next_pb = chanBNcoPhaseWord;
      next_awAddr = awAddr;
      next_awHave = awHave;
      next_wData = wData;
      next_wStrb = wStrb;
      next_wHave = wHave;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      armSet = 1'b0;
      if (awvalid && awready)
      begin
         next_awAddr = awaddr;
         next_awHave = 1'b1;
      end
      if (wvalid && wready)
      begin
         next_wData = wdata;
         next_wStrb = wstrb;
         next_wHave = 1'b1;
      end
      if (bvalid && bready)
      begin
         next_bvalid = 1'b0;
      end
      // Commit once both halves of the write are held.
      if (awHave && wHave && !bvalid)
      begin
         ix = awAddr[4:2];
         next_awHave = 1'b0;
         next_wHave = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         if (awAddr == ADDR_CTRL)
         begin
            next_ctrl = merge(ctrl, wData, wStrb) & CTRL_MASK;
            armSet = wStrb[0] && wData[CTRL_ARM];
         end
         else if ((awAddr & ADDR_BANK_M) == ADDR_FREQ)
         begin
            if (ix[2])
               next_fb[ix[1:0]] = merge(chanBNcoFreqWord[ix[1:0]],
                                        wData, wStrb);
            else
               next_fa[ix[1:0]] = merge(chanANcoFreqWord[ix[1:0]],
                                        wData, wStrb);
         end
         else if ((awAddr & ADDR_BANK_M) == ADDR_PHASE)
         begin
            if (ix[2])
               next_pb[ix[1:0]] = 16'(merge({16'h0000,
                  chanBNcoPhaseWord[ix[1:0]]}, wData, wStrb));
            else
               next_pa[ix[1:0]] = 16'(merge({16'h0000,
                  chanANcoPhaseWord[ix[1:0]]}, wData, wStrb));
         end
         else if (awAddr != ADDR_STATUS)
         begin
            next_bresp = RESP_SLVERR;
         end
      end
      next_awready = !next_awHave;
      next_wready = !next_wHave;
      if (rvalid && rready)
      begin
         next_rvalid = 1'b0;
      end
      // Read decode; unmapped addresses answer with an error and zero.
      if (arvalid && arready)
      begin
         ix = araddr[4:2];
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (araddr == ADDR_CTRL)
         begin
            next_rdata = ctrl;
            next_rdata[CTRL_ARM] = nextSysrefNcoAlignArm;
         end
         else if (araddr == ADDR_STATUS)
         begin
            next_rdata[STAT_ARMED] = nextSysrefNcoAlignArm;
            next_rdata[STAT_SYNC_ARM] = syncArmed;
            next_rdata[STAT_CGS] = codeGroupAlignment;
            next_rdata[STAT_CNT_LSB +: 8] = alignCount;
         end
         else if ((araddr & ADDR_BANK_M) == ADDR_FREQ)
            next_rdata = ix[2] ? chanBNcoFreqWord[ix[1:0]]
                               : chanANcoFreqWord[ix[1:0]];
         else if ((araddr & ADDR_BANK_M) == ADDR_PHASE)
            next_rdata[15:0] = ix[2] ? chanBNcoPhaseWord[ix[1:0]]
                                     : chanANcoPhaseWord[ix[1:0]];
         else
            next_rresp = RESP_SLVERR;
      end
      next_arready = !next_rvalid;
   end

   // Register file and bus registers.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl <= CTRL_RESET;
         chanANcoFreqWord <= '{default: WORD_RESET};
         chanBNcoFreqWord <= '{default: WORD_RESET};
         chanANcoPhaseWord <= '{default: 16'h0000};
         chanBNcoPhaseWord <= '{default: 16'h0000};
         awAddr <= 8'h00;
         awHave <= 1'b0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         wHave <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
      end
      else
      begin
         ctrl <= next_ctrl;
         chanANcoFreqWord <= next_fa;
         chanBNcoFreqWord <= next_fb;
         chanANcoPhaseWord <= next_pa;
         chanBNcoPhaseWord <= next_pb;
         awAddr <= next_awAddr;
         awHave <= next_awHave;
         wData <= next_wData;
         wStrb <= next_wStrb;
         wHave <= next_wHave;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // =====================================================================
   // Alignment triggers: a level counts once the last two stages agree.
   always_comb
   begin : align_next
      logic syncFall, syncRise, srefRise, linkOn;
      next_syncLvl = (syncPipe[1] == syncPipe[2]) ? syncPipe[2] : syncLvl;
      next_srefLvl = (srefPipe[1] == srefPipe[2]) ? srefPipe[2] : srefLvl;
      syncFall = syncLvl && !next_syncLvl;
      syncRise = !syncLvl && next_syncLvl;
      srefRise = !srefLvl && next_srefLvl;
      linkOn = ctrl[CTRL_LINK_EN];
      next_syncArmed = syncArmed;
      next_cga = codeGroupAlignment;
      alignNow = 1'b0;
      // SYNC low arms; 8b/10b also starts code group alignment.
      if (syncFall && linkOn && ctrl[CTRL_SYNC_EN])
      begin
         next_syncArmed = 1'b1;
         next_cga = !ctrl[CTRL_ENC64];
      end
      if (syncRise && syncArmed)
      begin
         alignNow = 1'b1;
         next_syncArmed = 1'b0;
         next_cga = 1'b0;
      end
      if (!linkOn)
      begin
         next_syncArmed = 1'b0;
         next_cga = 1'b0;
      end
      // SYSREF arm: a new arming write beats the clear of the old one.
      next_arm = nextSysrefNcoAlignArm;
      if (srefRise && nextSysrefNcoAlignArm)
      begin
         alignNow = 1'b1;
         next_arm = 1'b0;
      end
      if (armSet)
      begin
         next_arm = 1'b1;
      end
      next_alignCount = alignNow ? alignCount + 8'h01 : alignCount;
   end

   // Pin synchronisers and alignment state.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syncPipe <= 3'h7;
         srefPipe <= 3'h0;
         syncLvl <= 1'b1;
         srefLvl <= 1'b0;
         syncArmed <= 1'b0;
         codeGroupAlignment <= 1'b0;
         nextSysrefNcoAlignArm <= 1'b0;
         alignCount <= 8'h00;
         ncoAlignPulse <= 1'b0;
      end
      else
      begin
         syncPipe <= {syncPipe[1:0], syncReqN};
         srefPipe <= {srefPipe[1:0], sysref};
         syncLvl <= next_syncLvl;
         srefLvl <= next_srefLvl;
         syncArmed <= next_syncArmed;
         codeGroupAlignment <= next_cga;
         nextSysrefNcoAlignArm <= next_arm;
         alignCount <= next_alignCount;
         ncoAlignPulse <= alignNow;
      end
   end

   // =====================================================================
   // Phase accumulators: all eight load their offsets on alignment.
   always_comb
   begin
      for (int n = 0; n < 4; n++)
      begin
         next_accA[n] = alignNow ? {chanANcoPhaseWord[n], 16'h0000}
                                 : accA[n] + chanANcoFreqWord[n];
         next_accB[n] = alignNow ? {chanBNcoPhaseWord[n], 16'h0000}
                                 : accB[n] + chanBNcoFreqWord[n];
      end
      next_phA = accA[ctrl[CTRL_SELA_LSB +: 2]][31:16];
      next_phB = accB[ctrl[CTRL_SELB_LSB +: 2]][31:16];
   end

   // Accumulator registers and selected phase outputs.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         accA <= '{default: 32'h0000_0000};
         accB <= '{default: 32'h0000_0000};
         ncoPhaseA <= 16'h0000;
         ncoPhaseB <= 16'h0000;
      end
      else
      begin
         accA <= next_accA;
         accB <= next_accB;
         ncoPhaseA <= next_phA;
         ncoPhaseB <= next_phB;
      end
   end

   // =====================================================================
   // Decimation chain: the setting picks the first stage used.
   logic [NSTG-1:0]    stV;
   logic signed [14:0] stI [NSTG];
   logic signed [14:0] stQ [NSTG];
   logic [2:0]         first;
   dns_dec_type        decMode;
   logic               next_ddcValid;
   logic [15:0]        next_ddcI, next_ddcQ;

   assign decMode = dns_dec_type'(ctrl[CTRL_DEC_LSB +: 3]);
   assign first = 3'(4 - int'(decMode));

   for (genvar s = 0; s < NSTG; s++)
   begin : g_stage
      logic               inV;
      logic signed [14:0] inI;
      logic signed [14:0] inQ;
      if (s == 0)
      begin : g_head
         assign inV = (first == 3'(s)) && mixValid;
         assign inI = mixI;
         assign inQ = mixQ;
      end
      else
      begin : g_tail
         assign inV = (first == 3'(s)) ? mixValid
                    : (first < 3'(s)) && stV[s-1];
         assign inI = (first == 3'(s)) ? mixI : stI[s-1];
         assign inQ = (first == 3'(s)) ? mixQ : stQ[s-1];
      end
      dns_halfband_stage #(.IDX(s)) u_stage
      (
         .clock    (clock),
         .arst_n   (arst_n),
         .inValid  (inV),
         .inI      (inI),
         .inQ      (inQ),
         .outValid (stV[s]),
         .outI     (stI[s]),
         .outQ     (stQ[s])
      );
   end

   // Output words: decimated complex with flags, or real bypass.
   always_comb
   begin
      case (decMode)
         DEC_BY4, DEC_BY8, DEC_BY16, DEC_BY32:
         begin
            next_ddcValid = stV[NSTG-1];
            next_ddcI = {stI[NSTG-1], overrangeFlagLow};
            next_ddcQ = {stQ[NSTG-1], overrangeFlagHigh};
         end
         default:
         begin
            next_ddcValid = realValid;
            next_ddcI = {realIn, 4'h0};
            next_ddcQ = 16'h0000;
         end
      endcase
   end

   // Output sample registers.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ddcValid <= 1'b0;
         ddcI <= 16'h0000;
         ddcQ <= 16'h0000;
      end
      else
      begin
         ddcValid <= next_ddcValid;
         ddcI <= next_ddcI;
         ddcQ <= next_ddcQ;
      end
   end
endmodule : dns_ddc_nco_sync

/* shared/dns_pkg.sv */
// Constants shared by the DDC NCO alignment and decimation block.
// Assumes a 100 MHz device clock and an AXI4-Lite register port.
package dns_pkg;
   // =====================================================================
   // Register map
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic [7:0]  ADDR_FREQ    = 8'h40;
   localparam logic [7:0]  ADDR_PHASE   = 8'h60;
   localparam logic [7:0]  ADDR_BANK_M  = 8'hE0;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK    = 32'h0000_0F7B;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // =====================================================================
   // Control and status fields
   localparam int CTRL_LINK_EN  = 0;
   localparam int CTRL_SYNC_EN  = 1;
   localparam int CTRL_ARM      = 2;
   localparam int CTRL_ENC64    = 3;
   localparam int CTRL_DEC_LSB  = 4;
   localparam int CTRL_SELA_LSB = 8;
   localparam int CTRL_SELB_LSB = 10;
   localparam int STAT_ARMED    = 0;
   localparam int STAT_SYNC_ARM = 1;
   localparam int STAT_CGS      = 2;
   localparam int STAT_CNT_LSB  = 8;

   // Decimation settings held in the control register.
   typedef enum logic [2:0]
   {
      DEC_BYPASS = 3'h0,
      DEC_BY4    = 3'h1,
      DEC_BY8    = 3'h2,
      DEC_BY16   = 3'h3,
      DEC_BY32   = 3'h4
   } dns_dec_type;

   // =====================================================================
   // Half-band stages, a to e; outer taps listed from the edge inward.
   localparam int NSTG      = 5;
   localparam int STG_NH    [5] = '{2, 2, 3, 4, 14};
   localparam int STG_CTR   [5] = '{16, 1024, 8192, 65536, 262144};
   localparam int STG_SHIFT [5] = '{5, 11, 14, 17, 19};
   localparam int STG_COEF  [5][14] = '{
      '{-1, 9, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
      '{-65, 577, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
      '{109, -837, 4824, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
      '{-327, 2231, -8881, 39742, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
      '{-37, 118, -291, 612, -1159, 2031, -3356, 5308, -8140, 12284,
        -18628, 29455, -53191, 166059}};
endpackage : dns_pkg

/* tb/dns_link_rx.sv */
// Link receiver model driving the SYNC request line.
// Assumes the bench commands it on the device clock.
module dns_link_rx
(
   // Clock, reset and command.
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic wantLow,
   // SYNC line toward the device, active low.
   output logic      syncReqN
);
   timeunit 1ns;
   timeprecision 1ps;
   // SYNC stays high until asserted, then all devices see it released.
   always_ff @(posedge clock or negedge arst_n)
      if (!arst_n)
         syncReqN <= 1'b1;
      else
         syncReqN <= !wantLow;
endmodule : dns_link_rx

/* tb/dns_props.sv */
// Checker for the DDC alignment block, bound to its top ports.
// Assumes pins change just after rising clock edges.
module dns_props
(
   // Clock and reset.
   input wire logic clock,
   input wire logic arst_n,
   // Bus handshakes.
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // Alignment pins and outputs.
   input wire logic syncReqN,
   input wire logic sysref,
   input wire logic ncoAlignPulse,
   input wire logic codeGroupAlignment
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // =================================================================
   // Alignment follows filtered pin edges; bus answers stand.
   a_cga_from_sync: assert property
      ($rose(codeGroupAlignment) |-> !$past(syncReqN, 2))
      else $error("Code group flag without SYNC low.");
   a_align_edge: assert property
      (ncoAlignPulse |-> ($past(sysref, 2) && !$past(sysref, 6))
         || ($past(syncReqN, 2) && !$past(syncReqN, 6)))
      else $error("Alignment without a pin rising edge.");
   a_align_once: assert property
      (ncoAlignPulse |=> !ncoAlignPulse)
      else $error("Alignment pulse too long.");
   a_read_answer: assert property
      (arvalid && arready |=> rvalid)
      else $error("Read data late.");
   a_read_hold: assert property
      (rvalid && !rready |=> rvalid)
      else $error("Read data dropped.");
   a_read_block: assert property
      (rvalid |-> !arready)
      else $error("Read address taken while busy.");
   a_write_answer: assert property
      (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("Write response late.");
   a_write_hold: assert property
      (bvalid && !bready |=> bvalid)
      else $error("Write response dropped.");
endmodule : dns_props

bind dns_ddc_nco_sync dns_props u_props
(
   .clock, .arst_n, .awvalid, .awready, .wvalid, .wready, .bvalid,
   .bready, .arvalid, .arready, .rvalid, .rready, .syncReqN, .sysref,
   .ncoAlignPulse, .codeGroupAlignment
);

/* tb/dns_ddc_nco_sync_bench.sv */
// Bench for the DDC alignment and decimation block.
// Assumes the link receiver model drives SYNC.
module dns_ddc_nco_sync_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CT = dns_pkg::ADDR_CTRL;
   localparam logic [7:0] ST = dns_pkg::ADDR_STATUS;
   localparam logic [1:0] OK = dns_pkg::RESP_OKAY;
   logic clock, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, syncReqN, sysref, wantLow;
   logic mixValid, realValid, overrangeFlagLow, overrangeFlagHigh;
   logic ncoAlignPulse, codeGroupAlignment, ddcValid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic signed [14:0] mixI, mixQ;
   logic [11:0] realIn;
   logic [15:0] ncoPhaseA, ncoPhaseB, ddcI, ddcQ, gap, p;
   int fails, n_compared, cyc;
   logic [47:0] expR[$], expB[$], expD[$];

   dns_ddc_nco_sync DUT (.*);
   dns_link_rx u_rx (.clock, .arst_n, .wantLow, .syncReqN);

   // =================================================================
   // Clock, comparison and closing report.
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end

   task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      fails += expR.size() + expB.size() + expD.size();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // Bus master tasks; each holds its request until it is taken.
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
      @(posedge clock);
      expB.push_back(r);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
         @(posedge clock);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (awvalid || wvalid);
      while (!bvalid) @(posedge clock);
      bready <= 0;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [33:0] e);
      @(posedge clock);
      expR.push_back(e);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge clock); while (!arready);
      arvalid <= 0;
      do @(posedge clock); while (!rvalid);
      rready <= 0;
   endtask : rd

   task automatic sref();
      sysref <= 1;
      repeat (4) @(posedge clock);
      sysref <= 0;
      repeat (8) @(posedge clock);
   endtask : sref

   // Constant-input gain of the stages used by one factor.
   function automatic logic signed [14:0] dcg(logic signed [14:0] x, int k);
      longint a, c;
      a = x;
      for (int s = 4 - k; s < 5; s++)
      begin
         c = dns_pkg::STG_CTR[s];
         for (int t = 0; t < 14; t++)
            c += 2 * dns_pkg::STG_COEF[s][t];
         a = (a * c) >>> dns_pkg::STG_SHIFT[s];
      end
      return a[14:0];
   endfunction : dcg

   // Monitor takes the oldest note when a result appears; also timeout.
   always @(posedge clock)
   begin
      gap <= ddcValid ? 16'h1 : gap + 16'h1;
      cyc <= cyc + 1;
      if (bvalid && bready && expB.size() > 0)
         check("bresp", bresp, expB.pop_front());
      if (rvalid && rready && expR.size() > 0)
         check("read", {rresp, rdata}, expR.pop_front());
      if (ddcValid && expD.size() > 0)
         check("sample", {gap, ddcI, ddcQ}, expD.pop_front());
      if (cyc == 30000)
      begin
         fails++;
         test_done();
      end
   end

   // Main sequence.
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, wantLow, sysref} = '0;
      {mixValid, realValid, overrangeFlagHigh, arst_n} = '0;
      {awaddr, araddr, wdata, wstrb, mixI, mixQ, realIn} = '0;
      overrangeFlagLow = 1;
      void'($urandom(97199));
      repeat (3) @(posedge clock);
      arst_n <= 1;
      repeat (2) @(posedge clock);
      rd(CT, {OK, dns_pkg::CTRL_RESET});
      rd(8'hF0, {dns_pkg::RESP_SLVERR, 32'h0});
      wr(8'hF0, 32'hFFFF_FFFF, dns_pkg::RESP_SLVERR);
      v = $urandom & dns_pkg::CTRL_MASK;
      wr(CT, v, OK);
      rd(CT, {OK, v});
      for (int e = 0; e < 2; e++)
      begin
         p = 16'($urandom);
         wr(CT, 32'h0, OK);
         wr(8'h4C, v, OK);
         rd(8'h4C, {OK, v});
         wr(dns_pkg::ADDR_PHASE, {16'h0, p}, OK);
         wr(8'h70, {16'h0, ~p}, OK);
         wr(CT, 32'(3 + 8 * e), OK);
         wantLow <= 1;
         repeat (8) @(posedge clock);
         rd(ST, {OK, 24'(e), 8'(e ? 2 : 6)});
         wantLow <= 0;
         repeat (8) @(posedge clock);
         rd(ST, {OK, 24'(e + 1), 8'h0});
         check("phase", ncoPhaseA, p);
         check("phaseB", ncoPhaseB, 16'(~p));
      end
      wr(CT, 32'h5, OK);
      rd(ST, {OK, 32'h201});
      sref();
      rd(ST, {OK, 32'h300});
      sref();
      rd(ST, {OK, 32'h300});
      wr(CT, 32'h5, OK);
      sref();
      rd(ST, {OK, 32'h400});
      mixI <= 15'($urandom % 8192);
      mixQ <= -15'($urandom % 8192);
      mixValid <= 1;
      for (int k = 1; k < 5; k++)
      begin
         wr(CT, 32'(k * 16 + 1), OK);
         repeat (3000) @(posedge clock);
         expD.push_back({16'(2 << k), dcg(mixI, k), 1'b1,
            dcg(mixQ, k), 1'b0});
         repeat (80) @(posedge clock);
      end
      {mixValid, realValid} <= 2'h1;
      realIn <= 12'($urandom);
      wr(CT, 32'h1, OK);
      repeat (20) @(posedge clock);
      expD.push_back({16'h1, realIn, 4'h0, 16'h0});
      repeat (4) @(posedge clock);
      test_done();
   end
endmodule : dns_ddc_nco_sync_bench
